// >>> shared/iapm_params.svh
`ifndef IAPM_PARAMS_SVH
`define IAPM_PARAMS_SVH

// ----------------------------------------------------------------
// Command codes carried in the low seven command bits
// ----------------------------------------------------------------
`define IAPM_CODE_CHIP_ERASE   7'h01
`define IAPM_CODE_BLOCK_ERASE  7'h0D
`define IAPM_CODE_SECTOR_ERASE 7'h0B
`define IAPM_CODE_PROGRAM      7'h0E
`define IAPM_CODE_VERIFY       7'h0C
`define IAPM_CODE_SB1          7'h0F
`define IAPM_CODE_SB2          7'h03
`define IAPM_CODE_SB3          7'h05
`define IAPM_CODE_BOOT_CFG     7'h09
`define IAPM_CODE_CLK_DOUBLE   7'h08

// ----------------------------------------------------------------
// Key and selector bytes, and the three-bit block 1 address tag
// ----------------------------------------------------------------
`define IAPM_KEY_ERASE         8'h55
`define IAPM_KEY_PROG          8'hAA
`define IAPM_SEL_BOOT_CFG0     8'h5A
`define IAPM_SEL_BOOT_CFG1     8'hAA
`define IAPM_SEL_CLK_DOUBLE    8'h55
`define IAPM_BLK1_TAG          3'h7

// ----------------------------------------------------------------
// Field positions, sizes and timing
// ----------------------------------------------------------------
`define IAPM_CMD_IRQ_BIT       7
`define IAPM_CFG_IAP_EN_BIT    6
`define IAPM_STAT_BUSY_BIT     2
`define IAPM_SECTOR_BYTES      128
`define IAPM_STRAP_DELAY       2'h2
`define IAPM_RESET_BYTE        8'h00

`endif

// >>> shared/iapm_pkg.sv
package iapm_pkg;

  // ----------------------------------------------------------------
  // Decoded operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IAPM_OP_NONE,
    IAPM_OP_CHIP_ERASE,
    IAPM_OP_BLOCK_ERASE,
    IAPM_OP_SECTOR_ERASE,
    IAPM_OP_PROGRAM,
    IAPM_OP_VERIFY,
    IAPM_OP_SB1,
    IAPM_OP_SB2,
    IAPM_OP_SB3,
    IAPM_OP_BOOT_CFG0,
    IAPM_OP_BOOT_CFG1,
    IAPM_OP_CLK_DOUBLE
  } iapm_op_t;

  typedef enum logic [0:0] {
    IAPM_IDLE,
    IAPM_WAIT
  } iapm_state_t;

  // ----------------------------------------------------------------
  // Request to the flash array
  // ----------------------------------------------------------------
  typedef struct packed {
    iapm_op_t    op;
    logic [15:0] addr;
    logic [7:0]  data;
  } iapm_flash_cmd_t;

  // ----------------------------------------------------------------
  // Whole state of the mailbox
  // ----------------------------------------------------------------
  typedef struct packed {
    iapm_state_t     st;
    logic            dis_s1;
    logic            dis_s2;
    logic            xacc_s1;
    logic            xacc_s2;
    logic            irq_s1;
    logic            irq_s2;
    logic [1:0]      cap_cnt;
    logic            cap_done;
    logic            iap_dis;
    logic            irq_mode;
    logic            busy;
    logic            flash_req;
    iapm_flash_cmd_t fcmd;
    logic [7:0]      vdata;
    logic            vvalid;
    logic [2:0]      sec;
    logic [1:0]      boot;
    logic            clk2;
    logic            irq_out;
  } iapm_regs_t;

endpackage

// >>> core/iapm_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "iapm_params.svh"

module iapm_decode
  import iapm_pkg::*;
(
  // Mailbox bytes
  input  wire logic [6:0] code,
  input  wire logic [7:0] data_byte,
  input  wire logic [7:0] addr_high,
  // Decoded operation
  output iapm_op_t        op
);

  // Any unmatched code or key falls through to no operation
  always_comb begin
    op = IAPM_OP_NONE;
    case (code)
      `IAPM_CODE_CHIP_ERASE: begin
        if (data_byte == `IAPM_KEY_ERASE) op = IAPM_OP_CHIP_ERASE;
      end
      `IAPM_CODE_BLOCK_ERASE: begin
        if (data_byte == `IAPM_KEY_ERASE) op = IAPM_OP_BLOCK_ERASE;
      end
      `IAPM_CODE_SECTOR_ERASE: op = IAPM_OP_SECTOR_ERASE;
      `IAPM_CODE_PROGRAM:      op = IAPM_OP_PROGRAM;
      `IAPM_CODE_VERIFY:       op = IAPM_OP_VERIFY;
      `IAPM_CODE_SB1: begin
        if (data_byte == `IAPM_KEY_PROG) op = IAPM_OP_SB1;
      end
      `IAPM_CODE_SB2: begin
        if (data_byte == `IAPM_KEY_PROG) op = IAPM_OP_SB2;
      end
      `IAPM_CODE_SB3: begin
        if (data_byte == `IAPM_KEY_PROG) op = IAPM_OP_SB3;
      end
      `IAPM_CODE_BOOT_CFG: begin
        if (data_byte == `IAPM_KEY_PROG) begin
          if (addr_high == `IAPM_SEL_BOOT_CFG0) op = IAPM_OP_BOOT_CFG0;
          else if (addr_high == `IAPM_SEL_BOOT_CFG1) op = IAPM_OP_BOOT_CFG1;
          else op = IAPM_OP_NONE;
        end
      end
      `IAPM_CODE_CLK_DOUBLE: begin
        if (data_byte == `IAPM_KEY_PROG && addr_high == `IAPM_SEL_CLK_DOUBLE)
          op = IAPM_OP_CLK_DOUBLE;
      end
      default: op = IAPM_OP_NONE;
    endcase
  end

endmodule
`default_nettype wire

// >>> core/iapm_mailbox.sv
`timescale 1ns/10ps
`default_nettype none
`include "iapm_params.svh"

module iapm_mailbox
  import iapm_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Mailbox writes from the CPU
  input  wire logic       cmd_wr,
  input  wire logic [7:0] flash_command_reg,
  input  wire logic [7:0] flash_data_reg,
  input  wire logic [7:0] flash_addr_high_reg,
  input  wire logic [7:0] flash_addr_low_reg,
  input  wire logic [7:0] flash_config_reg,
  // Device pins
  input  wire logic       external_access_pin_n,
  input  wire logic       iap_disable_pin_n,
  input  wire logic       external_irq_one_pin_n,
  // Lock state
  input  wire logic       lock_level4,
  input  wire logic       block0_locked,
  input  wire logic       block1_locked,
  // Flash array
  output logic            flash_req,
  output iapm_flash_cmd_t flash_cmd,
  input  wire logic       flash_done,
  input  wire logic [7:0] flash_rdata,
  // Status and results
  output logic [7:0]      flash_status_reg,
  output logic [7:0]      verify_data,
  output logic            verify_valid,
  output logic [2:0]      security_bits,
  output logic [1:0]      boot_cfg_bits,
  output logic            clock_double,
  output logic            external_irq_one,
  output logic            iap_disabled
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  iapm_regs_t s_ff;
  iapm_regs_t nxt_s;
  iapm_op_t   dec_op;
  logic [1:0] tgt;
  logic       blk_lock;
  logic       gate;
  logic       allowed;
  logic       accept;
  logic       finish;
  logic [7:0] sec_mask;

  // Bit 1 says the address names a block, bit 0 which one
  function automatic logic [1:0] tgt_block(input logic [7:0] ah);
    if (!ah[7]) tgt_block = 2'h2;
    else if (ah[7:5] == `IAPM_BLK1_TAG) tgt_block = 2'h3;
    else tgt_block = 2'h0;
  endfunction

  iapm_decode u_decode (
    .code      (flash_command_reg[6:0]),
    .data_byte (flash_data_reg),
    .addr_high (flash_addr_high_reg),
    .op        (dec_op)
  );

  assign sec_mask = 8'(`IAPM_SECTOR_BYTES - 1);
  assign tgt      = tgt_block(flash_addr_high_reg);
  assign blk_lock = tgt[0] ? block1_locked : block0_locked;
  // Commands arriving while busy are dropped, not queued
  assign gate     = flash_config_reg[`IAPM_CFG_IAP_EN_BIT]
                    && !s_ff.iap_dis && s_ff.cap_done
                    && s_ff.st == IAPM_IDLE;

  always_comb begin
    allowed = 1'b1;
    case (dec_op)
      IAPM_OP_NONE: allowed = 1'b0;
      IAPM_OP_CHIP_ERASE:
        allowed = !s_ff.xacc_s2 && !lock_level4;
      IAPM_OP_BLOCK_ERASE,
      IAPM_OP_SECTOR_ERASE,
      IAPM_OP_PROGRAM,
      IAPM_OP_VERIFY:
        allowed = tgt[1] && !blk_lock;
      default: allowed = 1'b1;
    endcase
  end

  assign accept = cmd_wr && gate && allowed;
  assign finish = s_ff.st == IAPM_WAIT && flash_done;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.dis_s1    = iap_disable_pin_n;
    nxt_s.dis_s2    = s_ff.dis_s1;
    nxt_s.xacc_s1   = external_access_pin_n;
    nxt_s.xacc_s2   = s_ff.xacc_s1;
    nxt_s.irq_s1    = external_irq_one_pin_n;
    nxt_s.irq_s2    = s_ff.irq_s1;
    nxt_s.flash_req = 1'b0;
    nxt_s.vvalid    = 1'b0;
    // Strap is caught once the synchroniser holds post-reset samples
    if (!s_ff.cap_done) begin
      if (s_ff.cap_cnt == `IAPM_STRAP_DELAY) begin
        nxt_s.cap_done = 1'b1;
        nxt_s.iap_dis  = !s_ff.dis_s2;
      end else begin
        nxt_s.cap_cnt = 2'(s_ff.cap_cnt + 2'h1);
      end
    end
    case (s_ff.st)
      IAPM_IDLE: begin
        if (accept) begin
          nxt_s.st            = IAPM_WAIT;
          nxt_s.busy          = 1'b1;
          nxt_s.flash_req     = 1'b1;
          nxt_s.irq_mode      = flash_command_reg[`IAPM_CMD_IRQ_BIT];
          nxt_s.fcmd.op       = dec_op;
          nxt_s.fcmd.data     = flash_data_reg;
          nxt_s.fcmd.addr     = {flash_addr_high_reg, flash_addr_low_reg};
          if (dec_op == IAPM_OP_SECTOR_ERASE)
            nxt_s.fcmd.addr[7:0] = flash_addr_low_reg & ~sec_mask;
          else if (dec_op == IAPM_OP_BLOCK_ERASE)
            nxt_s.fcmd.addr[7:0] = `IAPM_RESET_BYTE;
        end
      end
      IAPM_WAIT: begin
        if (flash_done) begin
          nxt_s.st   = IAPM_IDLE;
          nxt_s.busy = 1'b0;
          case (s_ff.fcmd.op)
            IAPM_OP_VERIFY: begin
              nxt_s.vdata  = flash_rdata;
              nxt_s.vvalid = 1'b1;
            end
            IAPM_OP_CHIP_ERASE: begin
              nxt_s.sec  = 3'h0;
              nxt_s.boot = 2'h0;
            end
            IAPM_OP_SB1:        nxt_s.sec[0]  = 1'b1;
            IAPM_OP_SB2:        nxt_s.sec[1]  = 1'b1;
            IAPM_OP_SB3:        nxt_s.sec[2]  = 1'b1;
            IAPM_OP_BOOT_CFG0:  nxt_s.boot[0] = 1'b1;
            IAPM_OP_BOOT_CFG1:  nxt_s.boot[1] = 1'b1;
            IAPM_OP_CLK_DOUBLE: nxt_s.clk2    = 1'b1;
            default:            nxt_s.clk2    = s_ff.clk2;
          endcase
        end
      end
      default: nxt_s.st = IAPM_IDLE;
    endcase
    // One-cycle pulse suits the edge-triggered setting firmware selects
    if (s_ff.irq_mode && flash_config_reg[`IAPM_CFG_IAP_EN_BIT])
      nxt_s.irq_out = finish
                      && s_ff.fcmd.op != IAPM_OP_VERIFY;
    else
      nxt_s.irq_out = !s_ff.irq_s2;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff          <= '0;
      s_ff.dis_s1   <= 1'b1;
      s_ff.dis_s2   <= 1'b1;
      s_ff.xacc_s1  <= 1'b1;
      s_ff.xacc_s2  <= 1'b1;
      s_ff.irq_s1   <= 1'b1;
      s_ff.irq_s2   <= 1'b1;
      s_ff.st       <= IAPM_IDLE;
      s_ff.fcmd.op  <= IAPM_OP_NONE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    flash_status_reg                      = `IAPM_RESET_BYTE;
    flash_status_reg[`IAPM_STAT_BUSY_BIT] = s_ff.busy;
  end

  assign flash_req        = s_ff.flash_req;
  assign flash_cmd        = s_ff.fcmd;
  assign verify_data      = s_ff.vdata;
  assign verify_valid     = s_ff.vvalid;
  assign security_bits    = s_ff.sec;
  assign boot_cfg_bits    = s_ff.boot;
  assign clock_double     = s_ff.clk2;
  assign external_irq_one = s_ff.irq_out;
  assign iap_disabled     = s_ff.iap_dis;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_launch;
    accept ##1 (s_ff.busy && flash_req);
  endsequence

  sequence s_settle;
    finish ##1 !s_ff.busy;
  endsequence

  a_busy_launch: assert property (accept |-> s_launch)
    else $error("busy or request missing after accepted command");
  a_busy_clear: assert property (finish |-> s_settle)
    else $error("busy not cleared after completion");
  a_irq_done: assert property (finish && s_ff.irq_mode
      && flash_config_reg[`IAPM_CFG_IAP_EN_BIT]
      && s_ff.fcmd.op != IAPM_OP_VERIFY |=> external_irq_one)
    else $error("completion interrupt missing");
  a_pin_gated: assert property (s_ff.irq_mode
      && flash_config_reg[`IAPM_CFG_IAP_EN_BIT] && !finish
      |=> !external_irq_one)
    else $error("pin leaked into interrupt one");
  a_poll_pin: assert property (!s_ff.irq_mode
      |=> external_irq_one == !$past(s_ff.irq_s2))
    else $error("pin not passed in polling mode");
  a_cfg_gate: assert property (cmd_wr && !s_ff.busy
      && !flash_config_reg[`IAPM_CFG_IAP_EN_BIT] |=> !flash_req)
    else $error("command accepted while disabled");
  a_strap_block: assert property (s_ff.iap_dis && cmd_wr |=> !flash_req)
    else $error("command accepted with disable strap");
  a_chip_gate: assert property (accept && dec_op == IAPM_OP_CHIP_ERASE
      |-> !s_ff.xacc_s2 && !lock_level4)
    else $error("chip erase accepted while not allowed");
  a_block_sel: assert property (accept && (dec_op == IAPM_OP_PROGRAM
      || dec_op == IAPM_OP_SECTOR_ERASE || dec_op == IAPM_OP_BLOCK_ERASE)
      |-> tgt[1] && !blk_lock)
    else $error("bad or locked block accepted");
  a_sector_base: assert property (flash_req
      && flash_cmd.op == IAPM_OP_SECTOR_ERASE
      |-> (flash_cmd.addr[7:0] & sec_mask) == 8'h00)
    else $error("sector erase not aligned");
  a_ignore_bad: assert property (cmd_wr && !accept && !s_ff.busy
      |=> !s_ff.busy && !flash_req)
    else $error("refused command changed state");
  a_verify_data: assert property (finish && s_ff.fcmd.op == IAPM_OP_VERIFY
      |=> verify_valid && verify_data == $past(flash_rdata))
    else $error("verify data not returned");
  a_sec_set: assert property (finish && s_ff.fcmd.op == IAPM_OP_SB3
      |=> security_bits[2])
    else $error("security bit not set");

endmodule
`default_nettype wire

// >>> tb/test_iapm_mailbox.sv
`timescale 1ns/10ps
`default_nettype none

module test_iapm_mailbox
  import iapm_pkg::*;
  ;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic            sys_clk, arst_n, cmd_wr, fdone;
  logic [7:0]      cmd, dat, ah, al, cfg, frd;
  logic            xacc_n, dis_n, pin_n, lk4, b0l, b1l;
  logic            flash_req, verify_valid, clock_double;
  logic            external_irq_one, iap_disabled;
  iapm_flash_cmd_t flash_cmd;
  logic [7:0]      flash_status_reg, verify_data;
  logic [2:0]      security_bits;
  logic [1:0]      boot_cfg_bits;
  int              errors, tests_run, i;
  int unsigned     seed;
  logic [2:0]      m_sec;
  logic [1:0]      m_boot;
  logic            m_clk, m_dis;
  logic [31:0]     tbl [18];

  iapm_mailbox dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .cmd_wr(cmd_wr),
    .flash_command_reg(cmd), .flash_data_reg(dat),
    .flash_addr_high_reg(ah), .flash_addr_low_reg(al),
    .flash_config_reg(cfg), .external_access_pin_n(xacc_n),
    .iap_disable_pin_n(dis_n), .external_irq_one_pin_n(pin_n),
    .lock_level4(lk4), .block0_locked(b0l), .block1_locked(b1l),
    .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_done(fdone),
    .flash_rdata(frd), .flash_status_reg(flash_status_reg),
    .verify_data(verify_data), .verify_valid(verify_valid),
    .security_bits(security_bits), .boot_cfg_bits(boot_cfg_bits),
    .clock_double(clock_double), .external_irq_one(external_irq_one),
    .iap_disabled(iap_disabled)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reference decoder; refusal of any kind yields no operation
  function automatic iapm_op_t model_op(logic [7:0] c, d, h);
    logic ok;
    ok = (!h[7] && !b0l) || (h[7:5] == 3'b111 && !b1l);
    if (!cfg[6] || m_dis)
      return IAPM_OP_NONE;
    case (c[6:0])
      7'h01: if (d == 8'h55 && !xacc_n && !lk4) return IAPM_OP_CHIP_ERASE;
      7'h0D: if (d == 8'h55 && ok) return IAPM_OP_BLOCK_ERASE;
      7'h0B: if (ok) return IAPM_OP_SECTOR_ERASE;
      7'h0E: if (ok) return IAPM_OP_PROGRAM;
      7'h0C: if (ok) return IAPM_OP_VERIFY;
      7'h0F: if (d == 8'hAA) return IAPM_OP_SB1;
      7'h03: if (d == 8'hAA) return IAPM_OP_SB2;
      7'h05: if (d == 8'hAA) return IAPM_OP_SB3;
      7'h09: if (d == 8'hAA && h == 8'h5A) return IAPM_OP_BOOT_CFG0;
        else if (d == 8'hAA && h == 8'hAA) return IAPM_OP_BOOT_CFG1;
      7'h08: if (d == 8'hAA && h == 8'h55) return IAPM_OP_CLK_DOUBLE;
      default: ;
    endcase
    return IAPM_OP_NONE;
  endfunction

  task automatic run(logic [31:0] w, logic poke);
    iapm_op_t    op;
    logic [15:0] xa;
    int          n;
    op = model_op(w[31:24], w[23:16], w[15:8]);
    xa = w[15:0];
    if (op == IAPM_OP_BLOCK_ERASE) xa[7:0] = 8'h00;
    if (op == IAPM_OP_SECTOR_ERASE) xa[6:0] = 7'h00;
    {cmd, dat, ah, al} = w;
    cmd_wr = 1'b1;
    tick();
    cmd_wr = poke;
    chk(flash_req, op != IAPM_OP_NONE);
    chk(flash_status_reg, {op != IAPM_OP_NONE, 2'h0});
    chk(external_irq_one, 1'b0);
    if (op == IAPM_OP_NONE) begin
      tick();
      return;
    end
    chk(flash_cmd.op, op);
    if (op inside {[IAPM_OP_BLOCK_ERASE:IAPM_OP_VERIFY]})
      chk(flash_cmd.addr, xa);
    if (op == IAPM_OP_PROGRAM)
      chk(flash_cmd.data, w[23:16]);
    n = 2 + rnd() % 3;
    for (int k = 0; k < n; k++) begin
      tick();
      cmd_wr = 1'b0;
      chk(flash_req, 1'b0);
      chk(flash_status_reg, 8'h04);
    end
    fdone = 1'b1;
    frd = rnd();
    tick();
    fdone = 1'b0;
    case (op)
      IAPM_OP_SB1:        m_sec[0] = 1'b1;
      IAPM_OP_SB2:        m_sec[1] = 1'b1;
      IAPM_OP_SB3:        m_sec[2] = 1'b1;
      IAPM_OP_BOOT_CFG0:  m_boot[0] = 1'b1;
      IAPM_OP_BOOT_CFG1:  m_boot[1] = 1'b1;
      IAPM_OP_CLK_DOUBLE: m_clk = 1'b1;
      IAPM_OP_CHIP_ERASE: {m_sec, m_boot} = 5'h00;
      default: ;
    endcase
    chk(flash_status_reg, 8'h00);
    chk(external_irq_one, w[31] && op != IAPM_OP_VERIFY);
    if (op == IAPM_OP_VERIFY) begin
      chk(verify_valid, 1'b1);
      chk(verify_data, frd);
    end
    chk({security_bits, boot_cfg_bits, clock_double},
        {m_sec, m_boot, m_clk});
    tick();
    chk(external_irq_one, 1'b0);
  endtask

  task automatic do_reset(logic d);
    dis_n = d;
    arst_n = 1'b0;
    repeat (4) tick();
    chk({flash_req, flash_status_reg, external_irq_one, iap_disabled},
        11'h000);
    arst_n = 1'b1;
    {m_sec, m_boot, m_clk} = 6'h00;
    m_dis = !d;
    repeat (6) tick();
    chk(iap_disabled, !d);
  endtask

  task automatic pin_check(logic exp);
    pin_n = 1'b0;
    repeat (4) tick();
    chk(external_irq_one, exp);
    pin_n = 1'b1;
    repeat (4) tick();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, cmd_wr, fdone, cmd, dat, ah, al, frd} = '0;
    {xacc_n, dis_n, pin_n, lk4, b0l, b1l} = 6'b011000;
    cfg = 8'h40;
    seed = 32'h0000_0b9c;
    errors = 0;
    tests_run = 0;
    tbl = '{32'h8155_0000, 32'h0154_0000, 32'h0255_0000, 32'h8D55_0000,
            32'h0D55_E000, 32'h0D55_8000, 32'h8B00_12FF, 32'h8BAA_F081,
            32'h8C00_1234, 32'h8FAA_0000, 32'h03AA_0000, 32'h85AA_0000,
            32'h89AA_5A00, 32'h09AA_AA00, 32'h88AA_5500, 32'h0955_5A00,
            32'h8855_5500, 32'h0155_0000};
    do_reset(1'b1);
    foreach (tbl[j]) run(tbl[j], 1'b0);
    for (i = 0; i < 8; i++)
      run({rnd() | 8'h0E, rnd(), rnd() | 8'h60, rnd()} & 32'h8EFF_FFFF,
          i[0]);
    xacc_n = 1'b1;
    repeat (4) tick();
    run(32'h8155_0000, 1'b0);
    xacc_n = 1'b0;
    lk4 = 1'b1;
    repeat (4) tick();
    run(32'h8155_0000, 1'b0);
    b0l = 1'b1;
    run(32'h8E11_1234, 1'b0);
    run(32'h8E22_E234, 1'b0);
    b1l = 1'b1;
    run(32'h0B00_F000, 1'b0);
    {lk4, b0l, b1l} = 3'b000;
    cfg = 8'hBF;
    run(32'h8E33_1234, 1'b0);
    cfg = 8'h40;
    run(32'h0E44_0010, 1'b0);
    pin_check(1'b1);
    run(32'h8E55_0020, 1'b0);
    pin_check(1'b0);
    do_reset(1'b0);
    run(32'h0E66_0030, 1'b0);
    run(32'h8FAA_0000, 1'b0);
    do_reset(1'b1);
    run(32'h0E77_0040, 1'b0);
    finish_test();
  end

  initial begin
    #40000;
    errors++;
    finish_test();
  end

endmodule

`default_nettype wire
